/* sfrc_pkg.sv */
// Constants and types shared by the serial flash read-command sequencer.
`default_nettype none
package sfrc_pkg;
    // Read opcodes.
    localparam logic [7:0] OPC_LEGACY  = 8'hE8;
    localparam logic [7:0] OPC_HIGH    = 8'h0B;
    localparam logic [7:0] OPC_LOW     = 8'h03;
    localparam logic [7:0] OPC_PAGE    = 8'hD2;
    localparam logic [7:0] OPC_BUF1_HS = 8'hD4;
    localparam logic [7:0] OPC_BUF1_LS = 8'hD1;
    localparam logic [7:0] OPC_BUF2_HS = 8'hD6;
    localparam logic [7:0] OPC_BUF2_LS = 8'hD3;

    // Rising-edge counts, from select low, of the last bit of each phase.
    localparam logic [6:0] OPC_LAST   = 7'h07;
    localparam logic [6:0] ADDR_LAST  = 7'h1F;
    localparam logic [6:0] LONG_LAST  = 7'h3F;
    localparam logic [6:0] SHORT_LAST = 7'h27;

    // Last byte offset for each page size.
    localparam logic [9:0] LAST_BYTE_528 = 10'h20F;
    localparam logic [9:0] LAST_BYTE_512 = 10'h1FF;

    // Read data staging buffer.
    localparam int unsigned FIFO_WIDTH = 8;
    localparam int unsigned FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        ST_OPC   = 3'h0,
        ST_ADDR  = 3'h1,
        ST_DUMMY = 3'h2,
        ST_DATA  = 3'h3,
        ST_SKIP  = 3'h4
    } sfrc_state_type;

    typedef enum logic [2:0] {
        CMD_NONE   = 3'h0,
        CMD_LEGACY = 3'h1,
        CMD_HIGH   = 3'h2,
        CMD_LOW    = 3'h3,
        CMD_PAGE   = 3'h4,
        CMD_BUF1   = 3'h5,
        CMD_BUF2   = 3'h6
    } sfrc_cmd_type;

    typedef enum logic [1:0] {
        SRC_ARRAY = 2'h0,
        SRC_BUF1  = 2'h1,
        SRC_BUF2  = 2'h2
    } sfrc_src_type;

    typedef struct packed {
        sfrc_src_type src;
        logic [11:0]  page;
        logic [9:0]   offset;
    } sfrc_req_type;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } sfrc_pins_type;
endpackage
`default_nettype wire

/* sfrc_seq.sv */
// Read-command sequencer of a serial flash with its read data FIFO.
// Function
// - Legacy read: opcode E8H, three address bytes, four don't-care bytes, data.
// - 528-byte pages: upper 12 address bits page, lower 10 bits byte.
// - 512-byte pages: upper 12 of 21 bits page, lower nine byte.
// - Internal address counter advances by itself during a read.
// - Continuous reads cross into the next page without delay.
// - Continuous reads wrap from array end to first page.
// - Select rising ends the read and floats the output.
// - Array reads bypass both buffers and never alter them.
// - Fast read: opcode 0BH, three address bytes, one dummy byte.
// - Slow read: opcode 03H, three address bytes, no dummy.
// - Page read: opcode D2H, address, four don't-care bytes.
// - Page read wraps to the start of the same page.
// - Page read reaches any of the 4096 pages.
// - D4H/D1H read buffer one, D6H/D3H read buffer two.
// - 528-byte buffers: 14 ignored bits then 10-bit offset.
// - 512-byte buffers: 15 ignored bits then 9-bit offset.
// - Buffer read needs one don't-care byte before data.
// - Buffer read wraps from last byte to first.
// - Serial clock modes 0 and 3 both work.
// - Command starts at select low, 8-bit opcode, MSB first.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sfrc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire logic                     flush,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data
);
    // Pointers wrap naturally, so DEPTH must be a power of two.
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = DEPTH[AW:0];

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Handshakes and honest full and empty.
    assign in_ready  = cnt_q != FULL;
    assign out_valid = cnt_q != '0;
    assign push      = in_valid & in_ready & !flush;
    assign pop       = out_valid & out_ready & !flush;
    assign out_data  = mem_q[rd_q];

    // Storage has no reset; only pointers define what is valid.
    always_ff @(posedge clk)
    begin
        if (ce && push)
            mem_q[wr_q] <= in_data;
    end

    // Pointer and fill count; flush empties at once.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else if (ce)
        begin
            wr_q  <= flush ? '0 : wr_q + AW'(push);
            rd_q  <= flush ? '0 : rd_q + AW'(pop);
            cnt_q <= flush ? '0 : cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule // sfrc_fifo

////////////////////////////////////////////////////////////////////////////////
module sfrc_seq
    import sfrc_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    input  wire logic          cs_n,
    input  wire logic          sck,
    input  wire logic          si,
    input  wire logic          page512,
    output logic               so_out,
    output logic               so_oe_n,
    output sfrc_req_type       req,
    output logic               req_valid,
    input  wire logic          req_ready,
    input  wire logic [7:0]    rsp_data,
    input  wire logic          rsp_valid,
    output logic               rsp_ready
);
    logic [1:0]     rst_q;
    logic           rst_n_s;
    sfrc_pins_type  s1_q, s2_q, s3_q, lv_q, lv_d;
    logic           sck_rise, sck_fall, cs_act, cs_end;
    sfrc_state_type st_q, st_d;
    sfrc_cmd_type   cmd_q, opc_cmd;
    logic [6:0]     cnt_q;
    logic [23:0]    sr_q;
    logic [23:0]    addr_w;
    logic [7:0]     opc_w;
    logic [11:0]    pg_w, pg_nx;
    logic [9:0]     of_w, of_nx, last_b;
    logic [6:0]     dum_last;
    logic           mode_q, at_end, is_cont;
    logic           fetch_q, pend_q, drop_q, drv_q, so_q;
    logic           req_take, rsp_got, f_in_ready, f_out_valid;
    logic           opc_done, addr_done, bit0;
    logic [7:0]     f_out_data, sh_q;
    logic [2:0]     bit_q;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n_s = rst_q[1];

    // Pins cross in three flops; a level counts once stages two and three agree.
    always_ff @(posedge core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            s1_q <= 3'h6;
            s2_q <= 3'h6;
            s3_q <= 3'h6;
            lv_q <= 3'h6;
        end
        else if (ce)
        begin
            s1_q <= {cs_n, sck, si};
            s2_q <= s1_q;
            s3_q <= s2_q;
            lv_q <= lv_d;
        end
    end
    assign lv_d = sfrc_pins_type'((s2_q ~^ s3_q) & s3_q | (s2_q ^ s3_q) & lv_q);

    // Edges of the filtered levels; either idle clock level is fine.
    assign sck_rise = !lv_q.sck & lv_d.sck & cs_act;
    assign sck_fall = lv_q.sck & !lv_d.sck & cs_act;
    assign cs_act   = !lv_q.cs_n;
    assign cs_end   = !lv_q.cs_n & lv_d.cs_n;

    ////////////////////////////////////////////////////////////////////////////
    // Command and address decode, MSB first.
    assign addr_w    = {sr_q[22:0], lv_d.si};
    assign opc_w     = addr_w[7:0];
    assign opc_done  = sck_rise && st_q == ST_OPC && cnt_q == OPC_LAST;
    assign addr_done = sck_rise && st_q == ST_ADDR && cnt_q == ADDR_LAST;
    assign opc_cmd   = (opc_w == OPC_LEGACY) ? CMD_LEGACY :
                       (opc_w == OPC_HIGH) ? CMD_HIGH :
                       (opc_w == OPC_LOW) ? CMD_LOW :
                       (opc_w == OPC_PAGE) ? CMD_PAGE :
                       (opc_w == OPC_BUF1_HS || opc_w == OPC_BUF1_LS) ? CMD_BUF1 :
                       (opc_w == OPC_BUF2_HS || opc_w == OPC_BUF2_LS) ? CMD_BUF2 :
                       CMD_NONE;
    // Same split serves buffer offsets: high bits are ignored there.
    assign pg_w = page512 ? addr_w[20:9] : addr_w[21:10];
    assign of_w = page512 ? {1'b0, addr_w[8:0]} : addr_w[9:0];
    assign dum_last = (cmd_q == CMD_LEGACY || cmd_q == CMD_PAGE) ? LONG_LAST
                                                                 : SHORT_LAST;

    // Next state, stepped on clock rises; deselect returns it to ST_OPC at once.
    always_comb
    begin
        st_d = st_q;
        if (!cs_act)
            st_d = ST_OPC;
        else if (sck_rise)
        begin
            unique case (st_q)
                ST_OPC:   if (cnt_q == OPC_LAST)
                              st_d = (opc_cmd == CMD_NONE) ? ST_SKIP : ST_ADDR;
                ST_ADDR:  if (cnt_q == ADDR_LAST)
                              st_d = (cmd_q == CMD_LOW) ? ST_DATA : ST_DUMMY;
                ST_DUMMY: if (cnt_q == dum_last)
                              st_d = ST_DATA;
                ST_DATA:  st_d = ST_DATA;
                ST_SKIP:  st_d = ST_SKIP;
                default:  st_d = ST_SKIP;
            endcase
        end
    end

    // Input shifter, bit counter and command latch.
    always_ff @(posedge core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            st_q  <= ST_OPC;
            cnt_q <= 7'h00;
            sr_q  <= 24'h000000;
            cmd_q <= CMD_NONE;
        end
        else if (ce)
        begin
            st_q  <= st_d;
            cnt_q <= !cs_act ? 7'h00 : (sck_rise && st_q != ST_DATA) ? cnt_q + 7'h01 : cnt_q;
            sr_q  <= sck_rise ? addr_w : sr_q;
            cmd_q <= opc_done ? opc_cmd : cmd_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address counter; page wraps 4095 to 0 by plain overflow.
    assign is_cont = cmd_q == CMD_LEGACY || cmd_q == CMD_HIGH || cmd_q == CMD_LOW;
    assign last_b  = mode_q ? LAST_BYTE_512 : LAST_BYTE_528;
    assign at_end  = req.offset == last_b;
    assign of_nx   = at_end ? 10'h000 : req.offset + 10'h001;
    assign pg_nx   = (at_end && is_cont) ? req.page + 12'h001 : req.page;

    // One fetch in flight; the FIFO must have room for its answer.
    assign req_valid = fetch_q & !pend_q & !drop_q & f_in_ready & cs_act;
    assign req_take  = req_valid & req_ready;
    assign rsp_ready = drop_q | f_in_ready;
    assign rsp_got   = rsp_valid & rsp_ready;

    // Fetch control: an aborted read's late answer is thrown away.
    always_ff @(posedge core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            req     <= '0;
            mode_q  <= 1'b0;
            fetch_q <= 1'b0;
            pend_q  <= 1'b0;
            drop_q  <= 1'b0;
        end
        else if (ce)
        begin
            if (addr_done)
            begin
                req.page   <= pg_w;
                req.offset <= of_w;
                req.src    <= (cmd_q == CMD_BUF1) ? SRC_BUF1 :
                              (cmd_q == CMD_BUF2) ? SRC_BUF2 : SRC_ARRAY;
                mode_q     <= page512;
            end
            else if (req_take)
            begin
                req.page   <= pg_nx;
                req.offset <= of_nx;
            end
            fetch_q <= cs_end ? 1'b0 : (addr_done | fetch_q);
            pend_q  <= req_take | (pend_q & !rsp_got);
            drop_q  <= cs_end ? (pend_q & !rsp_got) | req_take : drop_q & !rsp_got;
        end
    end

    sfrc_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rst_n     (rst_n_s),
        .ce        (ce),
        .flush     (cs_end),
        .in_valid  (rsp_valid & !drop_q),
        .in_ready  (f_in_ready),
        .in_data   (rsp_data),
        .out_valid (f_out_valid),
        .out_ready (sck_fall && st_q == ST_DATA && bit_q == 3'h0),
        .out_data  (f_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output shifter on clock falls; an empty FIFO gives ones, not a stall.
    assign bit0 = bit_q == 3'h0;
    always_ff @(posedge core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            so_q  <= 1'b1;
            sh_q  <= 8'hFF;
            bit_q <= 3'h0;
            drv_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!cs_act)
            begin
                bit_q <= 3'h0;
                drv_q <= 1'b0;
            end
            else if (sck_fall && st_q == ST_DATA)
            begin
                so_q  <= bit0 ? (f_out_data[7] | !f_out_valid) : sh_q[7];
                sh_q  <= bit0 ? {f_out_data[6:0] | {7{!f_out_valid}}, 1'b1}
                              : {sh_q[6:0], 1'b1};
                bit_q <= bit_q + 3'h1;
                drv_q <= 1'b1;
            end
        end
    end
    assign so_out  = so_q;
    assign so_oe_n = !(cs_act && drv_q && st_q == ST_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the sequencer.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_s);

    property p_hiz_desel;
        !cs_act |-> so_oe_n;
    endproperty
    a_hiz_desel: assert property (p_hiz_desel) else $error("output driven while deselected");

    property p_hiz_phase;
        st_q != ST_DATA |-> so_oe_n;
    endproperty
    a_hiz_phase: assert property (p_hiz_phase) else $error("output driven before data");

    // The driver may only switch on at the first data fall, never at a rise.
    property p_oe_first_fall;
        $fell(so_oe_n) |-> $past(sck_fall) && $past(st_q) == ST_DATA;
    endproperty
    a_oe_first_fall: assert property (p_oe_first_fall) else $error("output enabled off a fall");

    property p_opc_len;
        opc_done && ce && cs_act && lv_d.cs_n == 1'b0 |=> st_q != ST_OPC;
    endproperty
    a_opc_len: assert property (p_opc_len) else $error("opcode not taken at bit 8");

    property p_low_nodummy;
        addr_done && cmd_q == CMD_LOW && ce && !lv_d.cs_n |=> st_q == ST_DATA;
    endproperty
    a_low_nodummy: assert property (p_low_nodummy) else $error("slow read waited");

    property p_high_dummy;
        addr_done && cmd_q == CMD_HIGH && ce && !lv_d.cs_n |=> st_q == ST_DUMMY;
    endproperty
    a_high_dummy: assert property (p_high_dummy) else $error("fast read skipped dummy");

    property p_cont_next;
        req_take && is_cont && at_end && ce
            |=> req.offset == 10'h000 && req.page == $past(req.page) + 12'h001;
    endproperty
    a_cont_next: assert property (p_cont_next) else $error("no next page");

    property p_page_wrap;
        req_take && cmd_q == CMD_PAGE && at_end && ce
            |=> req.offset == 10'h000 && $stable(req.page);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page read left page");

    property p_buf_wrap;
        req_take && req.src != SRC_ARRAY && at_end && ce |=> req.offset == 10'h000;
    endproperty
    a_buf_wrap: assert property (p_buf_wrap) else $error("buffer did not wrap");

    property p_array_src;
        req_valid && (is_cont || cmd_q == CMD_PAGE) |-> req.src == SRC_ARRAY;
    endproperty
    a_array_src: assert property (p_array_src) else $error("array read used buffer");

    property p_split528;
        addr_done && !page512 && ce |=> req.page == $past(addr_w[21:10]);
    endproperty
    a_split528: assert property (p_split528) else $error("bad 528 page split");

    property p_so_fall;
        !$stable(so_out) |-> $past(sck_fall);
    endproperty
    a_so_fall: assert property (p_so_fall) else $error("output moved off a fall");

    c_cont_cross: cover property (req_take && is_cont && at_end);
    c_buf_read:   cover property (st_q == ST_DATA && req.src == SRC_BUF2);
    c_abort:      cover property (cs_end && st_q == ST_DATA);
    c_fifo_full:  cover property (!f_in_ready && fetch_q);
endmodule // sfrc_seq
`default_nettype wire

/* sfrc_mem_model.sv */
// Behavioural memory that answers the read sequencer's fetch requests.
`timescale 1ns/1ps
`default_nettype none

module sfrc_mem_model
    import sfrc_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [1:0]   lat,
    input  wire sfrc_req_type req,
    input  wire logic         req_valid,
    output logic              req_ready,
    output logic [7:0]        rsp_data,
    output logic              rsp_valid,
    input  wire logic         rsp_ready,
    output logic [15:0]       buf_reads
);
    logic       pend_q;
    logic [1:0] cnt_q;
    logic [7:0] data_q;

    // Content of each location; buffer bytes ignore the page field.
    function automatic logic [7:0] pat(input sfrc_src_type s, input logic [11:0] p,
                                       input logic [9:0] o);
        if (s == SRC_ARRAY)
            return o[7:0] ^ {o[9:8], 2'h0, p[3:0]} ^ p[11:4];
        return o[7:0] ^ {o[9:8], s, 4'h9};
    endfunction

    // Only one fetch is in flight, so a new one waits for the answer.
    assign req_ready = !pend_q && !rsp_valid;

    // Answer lat cycles after the take; a released data bus shows the inverse.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pend_q    <= 1'b0;
            cnt_q     <= 2'h0;
            data_q    <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_data  <= 8'hA5;
            buf_reads <= 16'h0000;
        end
        else
        begin
            if (rsp_valid && rsp_ready)
            begin
                rsp_valid <= 1'b0;
                rsp_data  <= ~rsp_data;
            end
            if (req_valid && req_ready)
            begin
                pend_q <= 1'b1;
                cnt_q  <= lat;
                data_q <= pat(req.src, req.page, req.offset);
                if (req.src != SRC_ARRAY)
                    buf_reads <= buf_reads + 16'h0001;
            end
            else if (pend_q && cnt_q > 2'h1)
                cnt_q <= cnt_q - 2'h1;
            else if (pend_q)
            begin
                pend_q    <= 1'b0;
                rsp_valid <= 1'b1;
                rsp_data  <= data_q;
            end
        end
    end
endmodule // sfrc_mem_model

`default_nettype wire

/* sfrc_tb.sv */
// Self-checking testbench of the serial flash read-command sequencer.
`timescale 1ns/1ps
`default_nettype none

module test_serial_flash_read_commands import sfrc_pkg::*;;
    logic         core_clk = 1'b0;
    logic         rstn;
    logic         cs_n;
    logic         sck;
    logic         si;
    logic         page512;
    logic         so_out;
    logic         so_oe_n;
    sfrc_req_type req;
    logic         req_valid;
    logic         req_ready;
    logic [7:0]   rsp_data;
    logic         rsp_valid;
    logic         rsp_ready;
    logic [1:0]   lat;
    logic [15:0]  buf_reads;
    int           failures;
    int           cmp_count;

    // A 40 MHz core clock.
    always #12.5 core_clk = ~core_clk;

    sfrc_seq u_sfrc_seq (.core_clk(core_clk), .rstn(rstn), .ce(1'b1), .cs_n(cs_n),
        .sck(sck), .si(si), .page512(page512), .so_out(so_out), .so_oe_n(so_oe_n),
        .req(req), .req_valid(req_valid), .req_ready(req_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));

    sfrc_mem_model u_sfrc_mem_model (.core_clk(core_clk), .rstn(rstn), .lat(lat),
        .req(req), .req_valid(req_valid), .req_ready(req_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .buf_reads(buf_reads));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One bit: a half period of 4 core cycles, output sampled late in the high phase.
    task automatic xbit(input logic b, input logic oe, output logic r);
        sck <= 1'b0;
        si  <= b;
        repeat (4) @(posedge core_clk);
        sck <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        r = so_out;
        check(32'(so_oe_n), 32'(oe));
        @(posedge core_clk);
    endtask

    task automatic xbyte(input logic [7:0] tx, input logic oe, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
            xbit(tx[i], oe, rx[i]);
    endtask

    task automatic start_frame(input logic m3, input logic p512);
        page512 <= p512;
        sck     <= m3;
        repeat (2) @(posedge core_clk);
        cs_n <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    // The wait for the output to float is bounded; running out ends the run.
    task automatic end_frame(input logic m3);
        int n;
        sck <= m3;
        repeat (4) @(posedge core_clk);
        cs_n <= 1'b1;
        n = 0;
        @(negedge core_clk);
        while (so_oe_n !== 1'b1 && n < 8)
        begin
            @(negedge core_clk);
            n++;
        end
        check(32'(so_oe_n), 32'h1);
        if (n == 8)
            tally_and_finish();
        repeat (8) @(posedge core_clk);
    endtask

    // kind 0 continuous, 1 page read, 2 buffer read; offsets advance as the host expects.
    task automatic frame(input logic [7:0] opc, input logic m3, input logic p512,
                         input int kind, input int ndum, input int nrd,
                         input logic [11:0] pg, input logic [9:0] off);
        logic [23:0]  a;
        logic [7:0]   rx;
        logic [9:0]   last;
        logic [15:0]  b0;
        sfrc_src_type s;
        s = (kind < 2) ? SRC_ARRAY :
            ((opc == OPC_BUF1_HS || opc == OPC_BUF1_LS) ? SRC_BUF1 : SRC_BUF2);
        last = p512 ? LAST_BYTE_512 : LAST_BYTE_528;
        if (kind == 2)
            a = p512 ? {15'h7FFF, off[8:0]} : {14'h3FFF, off};
        else
            a = p512 ? {3'h7, pg, off[8:0]} : {2'h3, pg, off};
        b0 = buf_reads;
        start_frame(m3, p512);
        xbyte(opc, 1'b1, rx);
        for (int k = 2; k >= 0; k--)
            xbyte(a[8*k +: 8], 1'b1, rx);
        repeat (ndum) xbyte(8'hC3, 1'b1, rx);
        for (int k = 0; k < nrd; k++)
        begin
            xbyte(8'h00, 1'b0, rx);
            check(32'(rx), 32'(u_sfrc_mem_model.pat(s, pg, off)));
            if (off == last)
            begin
                off = 10'h000;
                if (kind == 0)
                    pg = pg + 12'h001;
            end
            else
                off = off + 10'h001;
        end
        end_frame(m3);
        if (kind < 2)
            check(32'(buf_reads), 32'(b0));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_continuous();
        frame(OPC_LEGACY, 1'b0, 1'b0, 0, 4, 3, 12'h005, 10'h20E);
        // A slow memory only fits where a dummy byte gives the first fetch slack.
        lat <= 2'h2;
        frame(OPC_HIGH, 1'b1, 1'b1, 0, 1, 3, 12'hFFF, 10'h1FE);
        // The slow read has no dummy, so its first byte must come back in one cycle.
        lat <= 2'h1;
        frame(OPC_LOW, 1'b1, 1'b0, 0, 0, 3, 12'hFFF, 10'h20F);
        $display("continuous reads done");
    endtask

    task automatic t_page();
        frame(OPC_PAGE, 1'b1, 1'b0, 1, 4, 3, 12'h800, 10'h20E);
        frame(OPC_PAGE, 1'b0, 1'b1, 1, 4, 2, 12'h7FF, 10'h1FF);
        $display("page reads done");
    endtask

    // Every buffer opcode, both page sizes, starting on the last byte.
    // The link clock here is slow enough for the low-rate opcodes as well.
    task automatic t_buffer();
        logic [7:0] ops [4];
        ops = '{OPC_BUF1_HS, OPC_BUF1_LS, OPC_BUF2_HS, OPC_BUF2_LS};
        for (int i = 0; i < 4; i++)
            frame(ops[i], i[0], i[1], 2, 1, 2, 12'h000, i[1] ? 10'h1FF : 10'h20F);
        $display("buffer reads done");
    endtask

    // Cut a read inside its first byte, read again at once, then a refused opcode.
    task automatic t_abort();
        logic [7:0] rx;
        logic [23:0] a;
        a = {2'h3, 12'h020, 10'h100};
        start_frame(1'b1, 1'b0);
        xbyte(OPC_HIGH, 1'b1, rx);
        for (int k = 2; k >= 0; k--)
            xbyte(a[8*k +: 8], 1'b1, rx);
        xbyte(8'h00, 1'b1, rx);
        for (int i = 0; i < 3; i++)
            xbit(1'b0, 1'b0, rx[i]);
        end_frame(1'b1);
        frame(OPC_HIGH, 1'b1, 1'b0, 0, 1, 2, 12'h010, 10'h000);
        start_frame(1'b0, 1'b0);
        xbyte(8'h5A, 1'b1, rx);
        repeat (4) xbyte(8'h00, 1'b1, rx);
        end_frame(1'b0);
        $display("abort and refusal done");
    endtask

    // Watchdog against a hang anywhere in the sequence.
    initial
    begin
        repeat (100000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end

    // Main sequence.
    initial
    begin
        rstn      = 1'b0;
        cs_n      = 1'b1;
        sck       = 1'b0;
        si        = 1'b0;
        page512   = 1'b0;
        lat       = 2'h1;
        failures  = 0;
        cmp_count = 0;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge core_clk);
        t_continuous();
        t_page();
        t_buffer();
        t_abort();
        tally_and_finish();
    end
endmodule // test_serial_flash_read_commands

`default_nettype wire
